// ---- sitrw_host.sv ----
// Bus master model for the serial target, open drain on both lines.
`timescale 1ns/1ps
module sitrw_host #(
   parameter int H = 2500
) (
   input  wire logic i_scl,
   input  wire logic i_sda,
   output logic      o_scl_oe,
   output logic      o_sda_oe
);
   int n_stall = 0;
   int hp      = H;
   initial {o_scl_oe, o_sda_oe} = 2'b00;
   // ==========================================================================
   // Line tasks
   // The target may stretch the clock, so each release waits, but never forever.
   // After one stall the model stops waiting, so a hung target cannot drag the run out.
   task automatic rel_scl();
      int k;
      o_scl_oe = 1'b0;
      for (k = 0; k < 2000 && n_stall == 0 && i_scl !== 1'b1; k++)
         #50;
      if (k == 2000)
         n_stall++;
   endtask
   // Data moves half a low phase after the fall, so the target never sees a false start.
   task automatic bitx(input logic b, output logic s);
      #(hp/2) o_sda_oe = ~b;
      #(hp/2) rel_scl();
      #hp s = i_sda;
      o_scl_oe = 1'b1;
   endtask
   task automatic cond(input logic st);
      #(hp/2) o_sda_oe = ~st;
      #(hp/2) rel_scl();
      #hp o_sda_oe = st;
      #hp o_scl_oe = st;
   endtask
   task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] r,
                       output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         bitx(d[i], r[i]);
      bitx(last, s);
      ack = ~s;
   endtask
endmodule

// ---- sitrw_pkg.sv ----
// Constants and carrier types for the sensor serial target with ready window.
package sitrw_pkg;

   // ==========================================================================
   // Register map
   localparam logic [7:0] ADDR_TIMEOUT  = 8'hd9;
   localparam logic [7:0] ADDR_SETTINGS = 8'hda;
   localparam logic [7:0] RST_SETTINGS  = 8'h01;
   localparam logic [7:0] RST_PTR       = 8'h00;
   localparam int         STOP_OFF_BIT  = 7;

   // ==========================================================================
   // Bus address and one-time option bits
   localparam logic [6:0] BASE_ADDR     = 7'h44;
   localparam int         OTP_SUB3_BIT  = 3;
   localparam int         OTP_OSC_BIT   = 2;
   localparam int         OTP_TUNE_BIT  = 6;
   localparam int         BIT_CNT_BYTE  = 8;

   // ==========================================================================
   // Timing
   localparam int         CLK_PERIOD_NS  = 50;
   localparam int         TICK_NS        = 80000;
   localparam int         TICK_CYCLES    = TICK_NS / CLK_PERIOD_NS;
   localparam int         DEF_TIMEOUT_US = 10240;
   localparam logic [7:0] RST_TIMEOUT    = 8'(DEF_TIMEOUT_US * 1000 / TICK_NS);
   localparam int         STD_RATE_KBPS  = 100;
   localparam int         FAST_RATE_KBPS = 400;

   // ==========================================================================
   // Types
   typedef struct packed {
      logic       first;
      logic [7:0] data;
   } sitrw_wevt_t;

   typedef struct packed {
      logic       strobe;
      logic [7:0] addr;
      logic [7:0] data;
   } sitrw_regwr_t;

   typedef enum logic [3:0] {
      ST_IDLE     = 4'h0,
      ST_ADDR     = 4'h1,
      ST_ADDR_ACK = 4'h2,
      ST_WAIT_WIN = 4'h3,
      ST_RD_FETCH = 4'h4,
      ST_RD_BYTE  = 4'h5,
      ST_RD_ACK   = 4'h6,
      ST_WR_BYTE  = 4'h7,
      ST_WR_ACK   = 4'h8
   } sitrw_state_t;

endpackage

// ---- sitrw_sync.sv ----
// Three-stage synchroniser with an agreement filter on each bit.
`timescale 1ns/1ps
module sitrw_sync #(
   parameter int               WIDTH   = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input  wire logic             i_clock,
   input  wire logic             i_nrst,
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);

   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;

   always_ff @(posedge i_clock)
   begin
      meta   <= i_async;
      stage2 <= meta;
      stage3 <= stage2;
   end

   // ==========================================================================
   // A bit changes only once the last two stages agree, which masks a single
   // stage that resolved late.
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++)
      begin : g_bit
         always_ff @(posedge i_clock)
         begin
            if (!i_nrst)
               o_sync[g] <= RST_VAL[g];
            else if (stage2[g] == stage3[g])
               o_sync[g] <= stage3[g];
         end
      end
   endgenerate

endmodule

// ---- sitrw_target.sv ----
// Serial target with ready window, stop suppression and ready timeout.
//
// Function
// - Standard-mode serial target signalling fully compliant up to 100 kbit/s.
// - Also works up to 400 kbit/s without fast-mode fall-time guarantee.
// - Outside a window, acknowledge the address, then hold clock low until window.
// - Ready line is open-drain, active low, low while a window is open.
// - Current-address read returns bytes from the pointer; master NACKs the last.
// - Random read: pointer write, repeated start, read returns that register.
// - Writes carry a pointer byte first, then data; every byte acknowledged.
// - Close the window when neither bus line moves for the timeout period.
// - After 0x81 in the settings register, stops are ignored; window stays open.
// - Window ended by timeout without a stop: written commands are discarded.
// - Ready timeout defaults to 10.24 ms after reset and is writable.
// - Bus address is 0x44 ORed with option bits 3, 1 and 0.
// - Codes 0000b-0011b give 0x44-0x47; codes 1000b-1011b give 0x4C-0x4F.
// - Option bit 6 clear suppresses streaming windows during auto-tuning.
// - Option bit 2 selects main oscillator: 20 MHz clear, 4 MHz set.
// - Both streaming and event-driven reporting modes are supported.
`timescale 1ns/1ps
module sitrw_target
   import sitrw_pkg::*;
#(
   parameter int TICK_CYC = sitrw_pkg::TICK_CYCLES
) (
   input  wire logic                   I_CLOCK,
   input  wire logic                   I_NRST,
   input  wire logic                   I_LINK_CLOCK,
   input  wire logic                   I_SCL,
   output logic                        O_SCL_OUT,
   output logic                        O_SCL_OE,
   input  wire logic                   I_SDA,
   output logic                        O_SDA_OUT,
   output logic                        O_SDA_OE,
   output logic                        O_READY_OUT,
   output logic                        O_READY_OE,
   input  wire logic [7:0]             I_OTP_OPTION,
   input  wire logic                   I_AUTO_TUNING,
   input  wire logic                   I_EVENT_MODE,
   input  wire logic                   I_REPORT_TICK,
   input  wire logic                   I_EVENT,
   input  wire logic [7:0]             I_REG_RDATA,
   output logic      [7:0]             O_REG_PTR,
   output sitrw_pkg::sitrw_regwr_t     O_REG_WRITE,
   output logic                        O_CMD_COMMIT,
   output logic                        O_CMD_DISCARD,
   output logic                        O_OSC_SLOW
);
   import sitrw_pkg::*;

   // ==========================================================================
   // Link domain declarations
   logic               link_nrst;
   logic [1:0]         pin_l;
   logic [8:0]         from_main_l;
   logic               scl_d;
   logic               sda_d;
   sitrw_state_t       state;
   logic [3:0]         cnt;
   logic [7:0]         shift;
   logic               rw;
   logic               first;
   logic               mack;
   logic               engaged;
   logic               wr_tgl;
   logic               rd_tgl;
   logic               stop_tgl;
   logic               rd_ack_q;
   sitrw_wevt_t        wevt;

   // Main domain declarations
   logic [4:0]         from_link_m;
   logic [2:0]         tgl_q;
   logic [1:0]         pins_q;
   logic [7:0]         otp;
   logic [6:0]         dev_addr;
   logic [7:0]         timeout_period;
   logic [7:0]         settings;
   logic [7:0]         rdata_m;
   logic               rd_ack_tgl;
   logic               wrote;
   logic [15:0]        prescale;
   logic [7:0]         ticks;

   // ==========================================================================
   // Crossings
   sitrw_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_rst_l (
      .i_clock (I_LINK_CLOCK),
      .i_nrst  (1'b1),
      .i_async (I_NRST),
      .o_sync  (link_nrst)
   );
   sitrw_sync #(.WIDTH(2), .RST_VAL(2'b11)) u_pin_l (
      .i_clock (I_LINK_CLOCK),
      .i_nrst  (link_nrst),
      .i_async ({I_SCL, I_SDA}),
      .o_sync  (pin_l)
   );
   sitrw_sync #(.WIDTH(9), .RST_VAL({7'h00, 2'b00})) u_to_link (
      .i_clock (I_LINK_CLOCK),
      .i_nrst  (link_nrst),
      .i_async ({dev_addr, O_READY_OE, rd_ack_tgl}),
      .o_sync  (from_main_l)
   );
   sitrw_sync #(.WIDTH(5), .RST_VAL(5'b00011)) u_to_main (
      .i_clock (I_CLOCK),
      .i_nrst  (I_NRST),
      .i_async ({wr_tgl, rd_tgl, stop_tgl, I_SCL, I_SDA}),
      .o_sync  (from_link_m)
   );

   // ==========================================================================
   // Link side decoding
   wire scl_l     = pin_l[1];
   wire sda_l     = pin_l[0];
   wire win_l     = from_main_l[1];
   wire rd_ack_l  = from_main_l[0];
   wire scl_rise  = scl_l & ~scl_d;
   wire scl_fall  = ~scl_l & scl_d;
   wire start_det = scl_l & scl_d & sda_d & ~sda_l;
   wire stop_det  = scl_l & scl_d & ~sda_d & sda_l;
   wire byte_done = (cnt == 4'(BIT_CNT_BYTE));
   wire addr_hit  = (shift[7:1] == from_main_l[8:2]);
   wire [7:0] shift_in = {shift[6:0], sda_l};

   // The rate limit comes from the link clock: every bus line is filtered
   // over several link cycles, so a quarter of a 400 kbit/s bit must span
   // at least the filter depth plus one.
   always_ff @(posedge I_LINK_CLOCK)
   begin
      scl_d <= scl_l;
      sda_d <= sda_l;
      O_SCL_OUT <= 1'b0;
      O_SDA_OUT <= 1'b0;
   end

   // ==========================================================================
   // Byte engine on the link clock
   always_ff @(posedge I_LINK_CLOCK)
   begin
      if (!link_nrst)
      begin
         state    <= ST_IDLE;
         O_SCL_OE <= 1'b0;
         O_SDA_OE <= 1'b0;
         cnt      <= 4'h0;
         shift    <= 8'h00;
         rw       <= 1'b0;
         first    <= 1'b0;
         mack     <= 1'b0;
         engaged  <= 1'b0;
         wr_tgl   <= 1'b0;
         rd_tgl   <= 1'b0;
         stop_tgl <= 1'b0;
         rd_ack_q <= 1'b0;
         wevt     <= '0;
      end
      else if (stop_det)
      begin
         state    <= ST_IDLE;
         O_SCL_OE <= 1'b0;
         O_SDA_OE <= 1'b0;
         engaged  <= 1'b0;
         if (engaged)
            stop_tgl <= ~stop_tgl;
      end
      else if (start_det)
      begin
         state    <= ST_ADDR;
         cnt      <= 4'h0;
         O_SCL_OE <= 1'b0;
         O_SDA_OE <= 1'b0;
      end
      else
      begin
         case (state)
            ST_IDLE: ;
            ST_ADDR:
               if (scl_rise)
               begin
                  shift <= shift_in;
                  cnt   <= cnt + 4'h1;
               end
               else if (scl_fall && byte_done)
               begin
                  if (addr_hit)
                  begin
                     O_SDA_OE <= 1'b1;
                     rw       <= shift[0];
                     engaged  <= 1'b1;
                     state    <= ST_ADDR_ACK;
                  end
                  else
                     state <= ST_IDLE;
               end
            ST_ADDR_ACK:
               if (scl_fall)
               begin
                  O_SDA_OE <= 1'b0;
                  O_SCL_OE <= 1'b1;
                  state    <= ST_WAIT_WIN;
               end
            ST_WAIT_WIN:
               if (win_l)
               begin
                  if (rw)
                  begin
                     rd_tgl <= ~rd_tgl;
                     state  <= ST_RD_FETCH;
                  end
                  else
                  begin
                     O_SCL_OE <= 1'b0;
                     cnt      <= 4'h0;
                     first    <= 1'b1;
                     state    <= ST_WR_BYTE;
                  end
               end
            ST_RD_FETCH:
               if (rd_ack_l != rd_ack_q)
               begin
                  rd_ack_q <= rd_ack_l;
                  shift    <= {rdata_m[6:0], 1'b0};
                  O_SDA_OE <= ~rdata_m[7];
                  O_SCL_OE <= 1'b0;
                  cnt      <= 4'h1;
                  state    <= ST_RD_BYTE;
               end
            ST_RD_BYTE:
               if (scl_fall)
               begin
                  if (byte_done)
                  begin
                     O_SDA_OE <= 1'b0;
                     state    <= ST_RD_ACK;
                  end
                  else
                  begin
                     O_SDA_OE <= ~shift[7];
                     shift    <= {shift[6:0], 1'b0};
                     cnt      <= cnt + 4'h1;
                  end
               end
            ST_RD_ACK:
               if (scl_rise)
                  mack <= ~sda_l;
               else if (scl_fall)
               begin
                  if (mack)
                  begin
                     O_SCL_OE <= 1'b1;
                     rd_tgl   <= ~rd_tgl;
                     state    <= ST_RD_FETCH;
                  end
                  else
                     state <= ST_IDLE;
               end
            ST_WR_BYTE:
               if (scl_rise)
               begin
                  shift <= shift_in;
                  cnt   <= cnt + 4'h1;
               end
               else if (scl_fall && byte_done)
               begin
                  O_SDA_OE <= 1'b1;
                  wevt     <= '{first: first, data: shift};
                  wr_tgl   <= ~wr_tgl;
                  state    <= ST_WR_ACK;
               end
            ST_WR_ACK:
               if (scl_fall)
               begin
                  O_SDA_OE <= 1'b0;
                  cnt      <= 4'h0;
                  first    <= 1'b0;
                  state    <= ST_WR_BYTE;
               end
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   // ==========================================================================
   // Main side decoding
   wire wr_evt       = from_link_m[4] ^ tgl_q[2];
   wire rd_evt       = from_link_m[3] ^ tgl_q[1];
   wire stop_evt     = from_link_m[2] ^ tgl_q[0];
   wire activity     = (from_link_m[1:0] != pins_q);
   wire stop_ignored = settings[STOP_OFF_BIT];
   wire stream_ok    = otp[OTP_TUNE_BIT] | ~I_AUTO_TUNING;
   wire open_req     = I_EVENT_MODE ? I_EVENT : (I_REPORT_TICK & stream_ok);
   wire tick         = (prescale == 16'(TICK_CYC - 1));
   wire expire       = O_READY_OE & (ticks >= timeout_period);
   wire close_stop   = O_READY_OE & stop_evt & ~stop_ignored;
   wire wr_data      = wr_evt & ~wevt.first;
   wire wr_ext       = wr_data & (O_REG_PTR != ADDR_TIMEOUT)
                       & (O_REG_PTR != ADDR_SETTINGS);
   wire [7:0] rd_mux = (O_REG_PTR == ADDR_TIMEOUT)  ? timeout_period :
                       (O_REG_PTR == ADDR_SETTINGS) ? settings : I_REG_RDATA;
   wire next_window  = (close_stop | expire) ? 1'b0 : (open_req | O_READY_OE);
   wire [7:0] next_ptr = (wr_evt & wevt.first) ? wevt.data :
                         (wr_data | rd_evt) ? 8'(O_REG_PTR + 8'h01) : O_REG_PTR;

   // Option bits 7, 5 and 4 are left to whoever programs them and are unused.
   always_ff @(posedge I_CLOCK)
   begin
      if (!I_NRST)
      begin
         otp        <= I_OTP_OPTION;
         dev_addr   <= BASE_ADDR;
         O_OSC_SLOW <= 1'b0;
      end
      else
      begin
         dev_addr   <= BASE_ADDR | {otp[OTP_SUB3_BIT], 1'b0, otp[1:0]};
         O_OSC_SLOW <= otp[OTP_OSC_BIT];
      end
   end

   // ==========================================================================
   // Window, timeout and register file
   always_ff @(posedge I_CLOCK)
   begin
      if (!I_NRST)
      begin
         tgl_q          <= 3'b000;
         pins_q         <= 2'b11;
         O_READY_OE     <= 1'b0;
         O_READY_OUT    <= 1'b0;
         prescale       <= 16'h0000;
         ticks          <= 8'h00;
         timeout_period <= RST_TIMEOUT;
         settings       <= RST_SETTINGS;
         O_REG_PTR      <= RST_PTR;
         O_REG_WRITE    <= '0;
         rdata_m        <= 8'h00;
         rd_ack_tgl     <= 1'b0;
         wrote          <= 1'b0;
         O_CMD_COMMIT   <= 1'b0;
         O_CMD_DISCARD  <= 1'b0;
      end
      else
      begin
         tgl_q       <= from_link_m[4:2];
         pins_q      <= from_link_m[1:0];
         O_READY_OE  <= next_window;
         O_READY_OUT <= 1'b0;
         prescale    <= (activity | ~O_READY_OE | tick) ? 16'h0000 : prescale + 16'h0001;
         ticks       <= (activity | ~O_READY_OE) ? 8'h00 : ticks + {7'h00, tick};
         if (wr_data && O_REG_PTR == ADDR_TIMEOUT)
            timeout_period <= wevt.data;
         if (wr_data && O_REG_PTR == ADDR_SETTINGS)
            settings <= wevt.data;
         O_REG_PTR   <= next_ptr;
         O_REG_WRITE <= '{strobe: wr_ext, addr: O_REG_PTR, data: wevt.data};
         if (rd_evt)
         begin
            rdata_m    <= rd_mux;
            rd_ack_tgl <= ~rd_ack_tgl;
         end
         wrote         <= (close_stop | expire) ? 1'b0 : (wrote | wr_ext);
         O_CMD_COMMIT  <= close_stop & (wrote | wr_ext);
         O_CMD_DISCARD <= expire & (wrote | wr_ext);
      end
   end

   // ==========================================================================
   // Checks
   chk_stop_close: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
      close_stop |=> !O_READY_OE)
      else $error("window stayed open after an enabled stop");
   chk_stop_ignore: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
      (O_READY_OE && stop_evt && stop_ignored && !expire) |=> O_READY_OE)
      else $error("window closed on an ignored stop");
   chk_timeout_close: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
      expire |=> !O_READY_OE ##1 !O_READY_OE || $past(open_req))
      else $error("window not closed by ready timeout");
   chk_timeout_discard: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
      (expire && wrote) |=> O_CMD_DISCARD && !O_CMD_COMMIT ##1 !O_CMD_DISCARD)
      else $error("written commands not discarded on timeout");
   chk_timeout_default: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
      $rose(I_NRST) |-> timeout_period == RST_TIMEOUT)
      else $error("ready timeout default wrong");
   chk_ready_open: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
      (open_req && !expire && !close_stop) |=> O_READY_OE && !O_READY_OUT)
      else $error("ready line not asserted low on window open");
   chk_tuning_gate: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
      (!I_EVENT_MODE && I_AUTO_TUNING && !otp[OTP_TUNE_BIT] && !O_READY_OE) |=> !O_READY_OE)
      else $error("streaming window opened during auto-tuning");
   chk_addr_map: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
      $past(I_NRST) |-> dev_addr[6:4] == 3'h4 && dev_addr[2]
         && dev_addr[3] == otp[OTP_SUB3_BIT] && dev_addr[1:0] == otp[1:0])
      else $error("bus address does not follow option bits");
   chk_ptr_advance: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
      (wr_data || rd_evt) |=> O_REG_PTR == 8'($past(O_REG_PTR) + 8'h01))
      else $error("pointer did not advance after a data byte");
   chk_read_reply: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
      rd_evt |=> rd_ack_tgl != $past(rd_ack_tgl) && rdata_m == $past(rd_mux))
      else $error("read request not answered");
   chk_stretch_wait: assert property (@(posedge I_LINK_CLOCK) disable iff (!link_nrst)
      (state == ST_WAIT_WIN || state == ST_RD_FETCH) |-> O_SCL_OE)
      else $error("clock released before data or window was ready");
   chk_addr_ack: assert property (@(posedge I_LINK_CLOCK) disable iff (!link_nrst)
      (state == ST_ADDR && scl_fall && byte_done && addr_hit && !stop_det && !start_det)
         |=> O_SDA_OE && state == ST_ADDR_ACK)
      else $error("own address not acknowledged");
   chk_write_ack: assert property (@(posedge I_LINK_CLOCK) disable iff (!link_nrst)
      state == ST_WR_ACK |-> O_SDA_OE)
      else $error("written byte not acknowledged");

   cov_window_open: cover property (@(posedge I_CLOCK) disable iff (!I_NRST)
      !O_READY_OE ##1 O_READY_OE);
   cov_stop_ignored: cover property (@(posedge I_CLOCK) disable iff (!I_NRST)
      O_READY_OE && stop_evt && stop_ignored);
   cov_timeout: cover property (@(posedge I_CLOCK) disable iff (!I_NRST) expire);
   cov_read_fetch: cover property (@(posedge I_LINK_CLOCK) disable iff (!link_nrst)
      state == ST_RD_ACK ##1 state == ST_RD_FETCH);

endmodule

// ---- tb.sv ----
// Bench for the serial target: host model, reference model and scenarios.
`timescale 1ns/1ps
module tb;
   import sitrw_pkg::*;
   logic         clk = 1'b0, lclk = 1'b0, nrst = 1'b0, tune = 1'b0, evm = 1'b1;
   logic         tick = 1'b0, evt = 1'b0, ack, scl_oe, sda_oe, h_scl, h_sda, ready;
   logic         com, dis, slow, sout, dout, rout;
   logic [7:0]   opt = 8'h00, ptr, m_ptr, m_to, m_set, r;
   logic [6:0]   dev;
   logic [31:0]  rnd = 32'h6b13;
   int           n_mismatch = 0, cmp_count = 0, n_com = 0, n_dis = 0;
   sitrw_regwr_t wr, q[$];
   wire          scl = ~(scl_oe | h_scl);
   wire          sda = ~(sda_oe | h_sda);
   wire [7:0]    rdata = ptr ^ 8'h5a;
   always #25 clk = ~clk;
   always #80 lclk = ~lclk;
   sitrw_target #(.TICK_CYC(8)) sitrw_target_i (
      .I_CLOCK(clk), .I_NRST(nrst), .I_LINK_CLOCK(lclk), .I_SCL(scl), .I_SDA(sda),
      .O_SCL_OUT(sout), .O_SCL_OE(scl_oe), .O_SDA_OUT(dout), .O_SDA_OE(sda_oe),
      .O_READY_OUT(rout), .O_READY_OE(ready), .I_OTP_OPTION(opt), .I_AUTO_TUNING(tune),
      .I_EVENT_MODE(evm), .I_REPORT_TICK(tick), .I_EVENT(evt), .I_REG_RDATA(rdata),
      .O_REG_PTR(ptr), .O_REG_WRITE(wr), .O_CMD_COMMIT(com), .O_CMD_DISCARD(dis),
      .O_OSC_SLOW(slow));
   sitrw_host sitrw_host_i (.i_scl(scl), .i_sda(sda), .o_scl_oe(h_scl), .o_sda_oe(h_sda));
   // ==========================================================================
   // Checking and reference model
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      cmp_count++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic conclude();
      n_mismatch += sitrw_host_i.n_stall;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   always @(negedge clk)
   begin
      n_com += int'(com === 1'b1);
      n_dis += int'(dis === 1'b1);
      if (wr.strobe === 1'b1)
      begin
         chk(wr.addr, q.size() > 0 ? q[0].addr : 8'hxx);
         chk(wr.data, q.size() > 0 ? q[0].data : 8'hxx);
         if (q.size() > 0)
            q.pop_front();
      end
   end
   task automatic rst(input logic [7:0] o);
      @(negedge clk);
      nrst = 1'b0;
      opt = o;
      repeat (20) @(negedge clk);
      nrst = 1'b1;
      repeat (12) @(posedge lclk);
      @(negedge clk);
      dev = 7'h44 | {3'h0, o[3], 1'b0, o[1:0]};
      {m_ptr, m_to, m_set} = {8'h00, 8'h80, 8'h01};
      chk(ptr, 8'h00);
      chk({7'h0, slow}, {7'h0, o[2]});
      chk({7'h0, ready}, 8'h00);
      chk({5'h0, sout, dout, rout}, 8'h00);
   endtask
   task automatic win(input logic e);
      @(negedge clk);
      {evt, tick} = evm ? 2'b10 : 2'b01;
      @(negedge clk);
      {evt, tick} = 2'b00;
      repeat (2) @(negedge clk);
      chk({7'h0, ready}, {7'h0, e});
   endtask
   task automatic closed();
      int k;
      for (k = 0; k < 3000 && ready !== 1'b0; k++)
         @(negedge clk);
      if (k == 3000)
      begin
         n_mismatch++;
         conclude();
      end
      repeat (4) @(negedge clk);
      chk(ptr, m_ptr);
   endtask
   task automatic ctrl(input logic rd);
      sitrw_host_i.cond(1'b1);
      sitrw_host_i.xfer({dev, rd}, 1'b1, r, ack);
      chk({7'h0, ack}, 8'h01);
   endtask
   // The expected write is queued first, as the strobe may come during the acknowledge.
   task automatic put(input logic [7:0] b, input logic f);
      if (!f && m_ptr != ADDR_TIMEOUT && m_ptr != ADDR_SETTINGS)
         q.push_back('{1'b1, m_ptr, b});
      m_to = (!f && m_ptr == ADDR_TIMEOUT) ? b : m_to;
      m_set = (!f && m_ptr == ADDR_SETTINGS) ? b : m_set;
      m_ptr = f ? b : m_ptr + 8'h01;
      sitrw_host_i.xfer(b, 1'b1, r, ack);
      chk({7'h0, ack}, 8'h01);
   endtask
   task automatic get(input logic l);
      sitrw_host_i.xfer(8'hff, l, r, ack);
      chk(r, m_ptr == ADDR_TIMEOUT ? m_to : m_ptr == ADDR_SETTINGS ? m_set : m_ptr ^ 8'h5a);
      m_ptr++;
   endtask
   // ==========================================================================
   // Scenarios
   initial
   begin
      for (int c = 0; c < 8; c++)
      begin
         rnd = lfsr(rnd);
         evm = rnd[9];
         rst({1'b0, rnd[6], 2'b00, c[2], rnd[2], c[1:0]});
         win(1'b1);
         sitrw_host_i.cond(1'b1);
         sitrw_host_i.xfer({dev ^ 7'h10, 1'b0}, 1'b1, r, ack);
         chk({7'h0, ack}, 8'h00);
         ctrl(1'b0);
         sitrw_host_i.cond(1'b0);
         closed();
      end
      $display("test 1 finished");
      rst(8'h00);
      ctrl(1'b0);
      repeat (300) @(negedge clk);
      chk({6'h0, scl_oe, scl}, 8'h02);
      win(1'b1);
      put(8'hff, 1'b1);
      put(rnd[7:0], 1'b0);
      put(rnd[15:8], 1'b0);
      sitrw_host_i.cond(1'b0);
      closed();
      chk(8'(n_com), 8'h01);
      $display("test 2 finished");
      win(1'b1);
      ctrl(1'b0);
      put(ADDR_TIMEOUT, 1'b1);
      ctrl(1'b1);
      get(1'b0);
      get(1'b1);
      sitrw_host_i.cond(1'b0);
      closed();
      sitrw_host_i.hp = 1250;
      win(1'b1);
      ctrl(1'b1);
      repeat (3) get(1'b0);
      get(1'b1);
      sitrw_host_i.cond(1'b0);
      closed();
      sitrw_host_i.hp = 2500;
      $display("test 3 finished");
      win(1'b1);
      ctrl(1'b0);
      put(ADDR_SETTINGS, 1'b1);
      put(8'h81, 1'b0);
      sitrw_host_i.cond(1'b0);
      repeat (200) @(negedge clk);
      chk({7'h0, ready}, 8'h01);
      ctrl(1'b0);
      put(8'h40, 1'b1);
      put(rnd[23:16], 1'b0);
      closed();
      chk(8'(n_dis), 8'h01);
      chk(8'(n_com), 8'h01);
      win(1'b1);
      ctrl(1'b0);
      put(ADDR_SETTINGS, 1'b1);
      put(8'h01, 1'b0);
      sitrw_host_i.cond(1'b0);
      closed();
      $display("test 4 finished");
      rst(8'h00);
      evm = 1'b0;
      tune = 1'b1;
      win(1'b0);
      tune = 1'b0;
      win(1'b1);
      rst(8'h40);
      tune = 1'b1;
      win(1'b1);
      $display("test 5 finished");
      conclude();
   end
endmodule
